/* rtl/osm_pkg.sv */
// Package of constants and types for the outgoing message serializer
package osm_pkg;

   // ******************************************************
   // Register map
   // ******************************************************
   localparam logic [7:0] OSM_ADDR_DATA = 8'h00;
   localparam logic [7:0] OSM_ADDR_CTRL = 8'h04;
   localparam logic [7:0] OSM_ADDR_STAT = 8'h08;
   localparam logic [7:0] OSM_ADDR_WORD = 8'h0c;

   localparam int OSM_PAYLOAD_W = 12;
   localparam logic [11:0] OSM_DATA_RST = 12'h000;
   localparam int OSM_CTRL_SEND = 0;
   localparam int OSM_CTRL_GO = 1;

   // ******************************************************
   // Message word layout (store bit n sits at index n-1)
   // ******************************************************
   localparam int OSM_WORD_W = 32;
   localparam logic [31:0] OSM_WORD_RST = 32'h0000_0000;
   localparam int OSM_POS_START = 27;
   localparam int OSM_POS_PAYLOAD_LO = 15;
   localparam int OSM_POS_OUT = 28;
   localparam int OSM_POS_PARITY_GATE = 8;
   localparam int OSM_POS_DONE = 11;
   localparam int OSM_POS_FORCE = 12;
   localparam int OSM_MSG_BITS = 13;

   // ******************************************************
   // Timing
   // ******************************************************
   localparam int OSM_CLK_HZ = 10_000_000;
   localparam int OSM_OSC_HZ_X10 = 205_880;
   localparam int OSM_TOTAL_DIV = 32;
   localparam int OSM_PRE_DIV = 2;
   localparam int OSM_BIT_DIV_W = 4;
   localparam int OSM_BIT_PERIOD_US = 1560;
   localparam int OSM_SLOT_CNT_W = 6;
   localparam logic [5:0] OSM_SLOT_STORE = 6'h00;
   localparam logic [5:0] OSM_SLOT_CONTROL = 6'h20;
   localparam int OSM_TIMEOUT_MS = 750;
   localparam int OSM_TICK_MS = 500;
   localparam int OSM_WAIT_STAGES = 3;

   // ******************************************************
   // Types
   // ******************************************************
   typedef struct packed {
      logic stop;
      logic parity;
      logic next_bit;
      logic present_bit;
      logic go;
      logic pending;
   } osm_status_t;

endpackage

/* rtl/osm_counter.sv */
// Free counter with enable, used for bit-rate divider and slot timer
`timescale 1ns/10ps
module osm_counter
#(
   parameter int W = 4
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic step,
   output logic [W-1:0] count
);

   logic [W-1:0] count_q;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= '0;
      end
      else if (step)
      begin
         count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign count = count_q;

endmodule

/* rtl/osm_timeout.sv */
// Go-ahead time-out made of wait flip-flops stepped by a slow tick
`timescale 1ns/10ps
module osm_timeout
   import osm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic slow_tick_120,
   input wire logic armed,
   output logic expired
);

   logic [OSM_WAIT_STAGES-1:0] wait_q;

   // Chain restarts whenever disarmed, so a late go-ahead wins cleanly
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q <= '0;
      end
      else if (!armed)
      begin
         wait_q <= '0;
      end
      else if (slow_tick_120)
      begin
         wait_q <= {wait_q[OSM_WAIT_STAGES-2:0], 1'b1};
      end
   end

   assign expired = wait_q[OSM_WAIT_STAGES-1] & armed;

endmodule

/* rtl/osm_serializer.sv */
// Outgoing message serializer: store word circulation and bit pacing
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module osm_serializer
   import osm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic receiver_timing_a,
   input wire logic slow_tick_120,
   input wire logic [2:0] incoming_start_go,
   output logic serial_out_a,
   output logic serial_out_b,
   output logic bit_rate_square_wave,
   output logic message_pending_flag,
   output logic no_message_pending,
   output logic stop_flag,
   output logic clear_message_word,
   output logic scan_logic_reset_pulse
);

   // ******************************************************
   // Declarations
   // ******************************************************
   logic [OSM_PAYLOAD_W-1:0] payload_q;
   logic [OSM_WORD_W-1:0] word_q;
   logic [OSM_WORD_W-1:0] out_reg;
   logic [31:0] rdata_q;
   logic pending_q;
   logic stop_q;
   logic go_q;
   logic next_bit_q;
   logic present_bit_q;
   logic parity_q;
   logic held_q;
   logic square_prev_q;
   logic timing_prev_q;
   logic done_q;
   logic clear_q;
   logic [OSM_BIT_DIV_W-1:0] bit_div;
   logic [OSM_SLOT_CNT_W-1:0] slot_cnt;
   logic timing_rise;
   logic store_slot;
   logic control_slot;
   logic square;
   logic square_fall;
   logic circulate_pulse;
   logic insert_parity_pulse;
   logic message_done_reset;
   logic go_ahead_detected;
   logic timeout_set;
   logic send_req;
   logic go_force;
   osm_status_t status;

   // ******************************************************
   // Bit-rate and slot timing
   // ******************************************************
   // Receiver timing already arrives halved, four stages finish /32
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timing_prev_q <= 1'b0;
      end
      else
      begin
         timing_prev_q <= receiver_timing_a;
      end
   end

   assign timing_rise = receiver_timing_a & ~timing_prev_q;

   osm_counter #(.W(OSM_BIT_DIV_W)) u_bit_div
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .step(timing_rise),
      .count(bit_div)
   );

   assign square = bit_div[OSM_BIT_DIV_W-1];

   osm_counter #(.W(OSM_SLOT_CNT_W)) u_slot
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .step(1'b1),
      .count(slot_cnt)
   );

   assign store_slot = (slot_cnt == OSM_SLOT_STORE);
   assign control_slot = (slot_cnt == OSM_SLOT_CONTROL);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         square_prev_q <= 1'b0;
      end
      else
      begin
         square_prev_q <= square;
      end
   end

   assign square_fall = square_prev_q & ~square;

   // ******************************************************
   // Register bus
   // ******************************************************
   assign send_req = reg_wr && (reg_addr == OSM_ADDR_CTRL)
                     && reg_wdata[OSM_CTRL_SEND];
   assign go_force = reg_wr && (reg_addr == OSM_ADDR_CTRL)
                     && reg_wdata[OSM_CTRL_GO];

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         payload_q <= OSM_DATA_RST;
      end
      else if (reg_wr && (reg_addr == OSM_ADDR_DATA))
      begin
         payload_q <= reg_wdata[OSM_PAYLOAD_W-1:0];
      end
   end

   assign status = '{stop: stop_q, parity: parity_q,
                     next_bit: next_bit_q, present_bit: present_bit_q,
                     go: go_q, pending: pending_q};

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (reg_rd)
      begin
         if (reg_addr == OSM_ADDR_DATA)
         begin
            rdata_q <= {20'h00000, payload_q};
         end
         else if (reg_addr == OSM_ADDR_STAT)
         begin
            rdata_q <= {26'h0000000, status};
         end
         else if (reg_addr == OSM_ADDR_WORD)
         begin
            rdata_q <= word_q;
         end
         else
         begin
            rdata_q <= 32'h0000_0000;
         end
      end
      else
      begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_q;

   // ******************************************************
   // Go-ahead
   // ******************************************************
   assign go_ahead_detected = control_slot && (&incoming_start_go);

   osm_timeout u_timeout
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .slow_tick_120(slow_tick_120),
      .armed(~go_q),
      .expired(timeout_set)
   );

   // Set wins over the end-of-message clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         go_q <= 1'b0;
      end
      else if (go_ahead_detected || timeout_set || go_force)
      begin
         go_q <= 1'b1;
      end
      else if (message_done_reset)
      begin
         go_q <= 1'b0;
      end
   end

   // ******************************************************
   // Circulate control
   // ******************************************************
   assign out_reg = {word_q[OSM_WORD_W-2:0], word_q[OSM_WORD_W-1]};
   assign circulate_pulse = pending_q && go_q && square && !held_q
                            && store_slot;
   // Marker tested in the stored word, so all 13 bits go out first
   assign insert_parity_pulse = circulate_pulse
                                && word_q[OSM_POS_PARITY_GATE];
   assign message_done_reset = circulate_pulse
                               && word_q[OSM_POS_DONE];

   // Hold-off stops a second circulate within one high phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         held_q <= 1'b0;
      end
      else if (circulate_pulse)
      begin
         held_q <= 1'b1;
      end
      else if (!square)
      begin
         held_q <= 1'b0;
      end
   end

   // ******************************************************
   // Message word
   // ******************************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_q <= OSM_WORD_RST;
      end
      else if (send_req && !pending_q)
      begin
         word_q <= OSM_WORD_RST;
         word_q[OSM_POS_START] <= 1'b1;
         word_q[OSM_POS_START-1:OSM_POS_PAYLOAD_LO] <= payload_q;
      end
      else if (!pending_q && store_slot)
      begin
         word_q <= OSM_WORD_RST;
      end
      else if (circulate_pulse)
      begin
         word_q <= out_reg;
         word_q[OSM_POS_FORCE] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clear_q <= 1'b0;
      end
      else
      begin
         clear_q <= !pending_q && store_slot && !stop_q;
      end
   end

   // ******************************************************
   // Pending and stop flags
   // ******************************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pending_q <= 1'b0;
         stop_q <= 1'b0;
      end
      else if (message_done_reset)
      begin
         pending_q <= 1'b0;
         stop_q <= 1'b0;
      end
      else if (send_req)
      begin
         pending_q <= 1'b1;
         stop_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= message_done_reset;
      end
   end

   // ******************************************************
   // Next bit, present bit and parity
   // ******************************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         next_bit_q <= 1'b0;
      end
      else if (message_done_reset)
      begin
         next_bit_q <= 1'b0;
      end
      else if (insert_parity_pulse)
      begin
         next_bit_q <= parity_q;
      end
      else if (circulate_pulse)
      begin
         next_bit_q <= out_reg[OSM_POS_OUT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         parity_q <= 1'b0;
      end
      else if (message_done_reset)
      begin
         parity_q <= 1'b0;
      end
      else if (circulate_pulse && !insert_parity_pulse
               && out_reg[OSM_POS_OUT])
      begin
         parity_q <= ~parity_q;
      end
   end

   // Transfer only on the falling phase while a message runs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         present_bit_q <= 1'b0;
      end
      else if (message_done_reset)
      begin
         present_bit_q <= 1'b0;
      end
      else if (square_fall && pending_q && go_q)
      begin
         present_bit_q <= next_bit_q;
      end
   end

   // ******************************************************
   // Outputs
   // ******************************************************
   assign serial_out_a = present_bit_q;
   assign serial_out_b = present_bit_q;
   assign bit_rate_square_wave = square;
   assign message_pending_flag = pending_q;
   assign no_message_pending = ~pending_q;
   assign stop_flag = stop_q;
   assign clear_message_word = clear_q;
   assign scan_logic_reset_pulse = done_q;

endmodule

/* tb/osm_checker.sv */
// Port-level assertion checker for the outgoing message serializer
`timescale 1ns/10ps
module osm_checker
   import osm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic serial_out_a,
   input wire logic serial_out_b,
   input wire logic bit_rate_square_wave,
   input wire logic message_pending_flag,
   input wire logic no_message_pending,
   input wire logic stop_flag,
   input wire logic clear_message_word,
   input wire logic scan_logic_reset_pulse
);
   // ******************************************************
   // Helper counters and checks
   // ******************************************************
   // Idle run must exceed one frame before the clear spacing is trusted
   logic [7:0] gap_q;
   logic [7:0] idle_q;
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         gap_q <= 8'h00;
      else if (clear_message_word)
         gap_q <= 8'h00;
      else if (gap_q != 8'hff)
         gap_q <= gap_q + 8'h01;
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         idle_q <= 8'h00;
      else if (message_pending_flag)
         idle_q <= 8'h00;
      else if (idle_q != 8'hff)
         idle_q <= idle_q + 8'h01;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_send;
      reg_wr && reg_addr == OSM_ADDR_CTRL && reg_wdata[OSM_CTRL_SEND]
         && no_message_pending;
   endsequence
   sequence s_msg_end;
      $fell(message_pending_flag);
   endsequence

   a_send_starts:
      assert property (s_send |=> message_pending_flag && stop_flag)
      else $error("send request not taken");
   a_twin_outputs:
      assert property (serial_out_a == serial_out_b)
      else $error("transmitter outputs differ");
   a_idle_zero:
      assert property (no_message_pending |-> !serial_out_a)
      else $error("serial output not idle");
   a_stop_inside:
      assert property (stop_flag |-> message_pending_flag)
      else $error("stop flag outside a message");
   a_clear_busy:
      assert property (clear_message_word |-> !stop_flag)
      else $error("word clear while sending");
   a_clear_slot:
      assert property (idle_q >= 8'd70 |->
         clear_message_word == (gap_q == 8'd63))
      else $error("idle clear not once per frame");
   a_end_pulse:
      assert property (s_msg_end |-> ##[0:1] scan_logic_reset_pulse)
      else $error("no reset pulse at message end");
   a_pulse_once:
      assert property (scan_logic_reset_pulse |=> !scan_logic_reset_pulse)
      else $error("reset pulse too long");
   a_bit_on_fall:
      assert property ($changed(serial_out_a) && message_pending_flag |->
         $fell(bit_rate_square_wave) || ($past(bit_rate_square_wave, 2)
         && !$past(bit_rate_square_wave)))
      else $error("present bit moved off the falling phase");
   a_rdata_quiet:
      assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule

bind osm_serializer osm_checker u_chk (
   .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .serial_out_a, .serial_out_b, .bit_rate_square_wave,
   .message_pending_flag, .no_message_pending, .stop_flag,
   .clear_message_word, .scan_logic_reset_pulse
);

/* tb/osm_far_end.sv */
// Far-end model: oscillator, slow tick, go-ahead bits and bit capture
`timescale 1ns/10ps
module osm_far_end
#(
   parameter int OSC_HALF = 8,
   parameter int TICK_CYC = 2000
)
(
   input wire logic core_clk,
   input wire logic serial_in,
   input wire logic bit_clk,
   output logic receiver_timing_a,
   output logic slow_tick_120,
   output logic [2:0] incoming_start_go,
   output logic [13:0] rx_bits,
   output logic [4:0] rx_cnt
);
   // ******************************************************
   // Timing sources and receiver
   // ******************************************************
   // Oscillator and tick run free, like the real sources
   int osc_cnt = 0;
   int tick_cnt = 0;
   logic clk_d = 1'b0;
   logic [2:0] fall_q = 3'h0;
   initial
   begin
      receiver_timing_a = 1'b0;
      slow_tick_120 = 1'b0;
      incoming_start_go = 3'h0;
      rx_bits = 14'h0;
      rx_cnt = 5'd0;
   end
   always @(posedge core_clk)
   begin
      osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == OSC_HALF - 1)
         receiver_timing_a <= !receiver_timing_a;
      tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 0 : tick_cnt + 1;
      slow_tick_120 <= (tick_cnt == TICK_CYC - 1);
      clk_d <= bit_clk;
      fall_q <= {fall_q[1:0], clk_d & !bit_clk};
      // Capture starts at the leading one, then takes 14 bits
      if (fall_q[2] && rx_cnt < 5'd14 && (rx_cnt != 5'd0 || serial_in))
      begin
         rx_bits <= {rx_bits[12:0], serial_in};
         rx_cnt <= rx_cnt + 5'd1;
      end
   end
   task automatic give_go(input logic [2:0] pat);
      incoming_start_go <= pat;
      repeat (70) @(posedge core_clk);
      incoming_start_go <= 3'h0;
   endtask
   task automatic rx_clear();
      rx_cnt <= 5'd0;
   endtask
endmodule

/* tb/testbench.sv */
// Self-checking testbench for the outgoing message serializer
`timescale 1ns/10ps
module testbench
   import osm_pkg::*;
;
   // ******************************************************
   // Bench
   // ******************************************************
   localparam int OSC_HALF = 8;
   localparam int SQ_NS = 16 * 2 * OSC_HALF * 100;
   localparam logic [11:0] P1 = 12'ha5c;
   localparam logic [11:0] P2 = 12'h001;
   logic core_clk, rst_n, reg_wr, reg_rd, receiver_timing_a, slow_tick_120;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0] incoming_start_go;
   logic serial_out_a, serial_out_b, bit_rate_square_wave, stop_flag;
   logic message_pending_flag, no_message_pending, clear_message_word;
   logic scan_logic_reset_pulse;
   logic [13:0] rx_bits;
   logic [4:0] rx_cnt;
   int errors, cmp_count;
   time t_rise = 0;
   logic [31:0] sq_per = 32'h0;

   osm_serializer u_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .receiver_timing_a, .slow_tick_120,
      .incoming_start_go, .serial_out_a, .serial_out_b, .bit_rate_square_wave,
      .message_pending_flag, .no_message_pending, .stop_flag,
      .clear_message_word, .scan_logic_reset_pulse);
   osm_far_end #(.OSC_HALF(OSC_HALF), .TICK_CYC(2000)) u_far (.core_clk,
      .serial_in(serial_out_a), .bit_clk(bit_rate_square_wave),
      .receiver_timing_a, .slow_tick_120, .incoming_start_go, .rx_bits,
      .rx_cnt);

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge bit_rate_square_wave)
   begin
      sq_per = 32'($time - t_rise);
      t_rise = $time;
   end

   task automatic give_verdict();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
      @(posedge core_clk);
   endtask
   task automatic wait_end(input int lim);
      int n;
      n = 0;
      while (scan_logic_reset_pulse !== 1'b1 && n < lim)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n == lim)
      begin
         errors++;
         $display("[FAIL] %0t: message never ended", $time);
         give_verdict();
      end
      @(posedge core_clk);
   endtask
   task automatic send(input logic [11:0] p);
      u_far.rx_clear();
      wr(OSM_ADDR_DATA, {20'h0, p});
      wr(OSM_ADDR_CTRL, 32'h1);
   endtask
   function automatic logic [31:0] frame(input logic [11:0] p);
      return {18'h0, 1'b1, p, ^{1'b1, p}};
   endfunction

   initial
   begin
      errors = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      check({31'h0, no_message_pending}, 32'h1);
      check({31'h0, serial_out_a}, 32'h0);
      wr(OSM_ADDR_STAT, 32'hffff_ffff);
      rd_chk(OSM_ADDR_STAT, 32'h0);
      rd_chk(8'h10, 32'h0);
      send(P1);
      rd_chk(OSM_ADDR_WORD, {5'h01, P1, 15'h0});
      rd_chk(OSM_ADDR_STAT, 32'h21);
      u_far.give_go(3'b110);
      rd_chk(OSM_ADDR_WORD, {5'h01, P1, 15'h0});
      u_far.give_go(3'b111);
      // A second send mid-message must be ignored
      wr(OSM_ADDR_DATA, 32'h0ff);
      wr(OSM_ADDR_CTRL, 32'h1);
      wait_end(6000);
      check({18'h0, rx_bits}, frame(P1));
      rd_chk(OSM_ADDR_STAT, 32'h0);
      check(sq_per, 32'(SQ_NS));
      repeat (70) @(posedge core_clk);
      rd_chk(OSM_ADDR_WORD, 32'h0);
      send(P2);
      wait_end(12000);
      check({18'h0, rx_bits}, frame(P2));
      wr(OSM_ADDR_CTRL, 32'h2);
      rd_chk(OSM_ADDR_STAT, 32'h2);
      send(P1);
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd_chk(OSM_ADDR_STAT, 32'h0);
      give_verdict();
   end
endmodule
